// ===== rtc_defs.svh
// Register offsets, field positions, reset values and timing constants of the real-time counter.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_A_CTRL 4'h0
`define RTC_A_STATUS 4'h1
`define RTC_A_INTCTRL 4'h2
`define RTC_A_INTFLAGS 4'h3
`define RTC_A_CNT 4'h4
`define RTC_A_PER 4'h5
`define RTC_A_CMP 4'h6
`define RTC_A_CLOCK_SOURCE_SELECT 4'h7
`define RTC_A_CORRECTION_VALUE_REGISTER 4'h8
`define RTC_A_PITCTRL 4'h9
`define RTC_A_PITINTCTRL 4'hA
`define RTC_A_PITFLAGS 4'hB
`define RTC_A_PITSTATUS 4'hC
`define RTC_B_CTRL 0
`define RTC_B_CNT 1
`define RTC_B_PER 2
`define RTC_B_CMP 3
`define RTC_B_PIT 4
`define RTC_F_OVF 0
`define RTC_F_CMP 1
`define RTC_ZERO16 16'h0000
`define RTC_PER_RST 16'hFFFF
`define RTC_PIT_MIN 4'h1
`define RTC_PIT_MAX 4'hE
`define RTC_PIT_DIV16 4'h3
`define RTC_EVT_LSB 5
`define RTC_EVT_MSB 12
`define RTC_CORR_WINDOW 20'hF_4240
`define RTC_ULP32_LAST 5'h1F
`endif

// ===== rtc_pkg.sv
// Types shared by the real-time counter and periodic timer.
package rtc_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} rtc_bus_t;
	typedef struct packed {
		logic [3:0] presc;
		logic corr;
		logic en;
	} rtc_ctrl_t;
	typedef struct packed {
		logic [3:0] period;
		logic en;
	} rtc_pitctrl_t;
	typedef struct packed {
		logic neg;
		logic [6:0] err;
	} rtc_correction_value_register_t;
	typedef enum logic [1:0] {rtc_src_xtal, rtc_src_ext, rtc_src_ulp, rtc_src_ulp32} rtc_clock_source_select_t;
endpackage : rtc_pkg

// ===== rtc_top.sv
// Real-time counter and periodic timer sharing one timebase prescaler.
// Overview of operation
// - Count prescaled ticks in 16 bits, compare with period and compare values.
// - Compare event on first count after counter equals compare value.
// - Wrap event on first count after counter equals period value.
// - Wrap returns counter to zero, cycling zero to period.
// - Timebase from crystal, external clock, low-power oscillator, or oscillator/32.
// - Timebase divided by a programmable 15-bit prescaler before the counter.
// - Correction adjustable in one ppm steps up to 127 ppm either way.
// - Correction skips counts or inserts counts depending on error sign.
// - Periodic timer shares the timebase and is enabled independently.
// - Periodic irq every 4 to 32768 clocks; level events 64 to 8192.
// - Counter enable bit starts and stops the counter.
// - Periodic timer enable bit starts and stops the periodic timer.
// - Counter and periodic timer derive timing from one prescaler counter.
// - Prescaler stopped when both enables clear, runs when either set.
// - First tick after enable comes anywhere within one full period.
// - Periodic output toggles every half period while the periodic timer is enabled with period 1 to 14.
// - Divide-by-sixteen setting follows prescaler bit 3, period sixteen clocks.
// - Correction adds or removes error-value cycles per million cycles.
// - Interrupt request while flag and enable set, until flag cleared.
// - Counter and timer run from timebase, updates apply after synchronisation.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`include "rtc_defs.svh"
module rtc_top #(
	parameter logic [19:0] CORR_WINDOW = `RTC_CORR_WINDOW
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input rtc_pkg::rtc_bus_t bus,
	output logic [15:0] rdata,
	// Timebase sources
	input wire logic crystal_input_pin,
	input wire logic ext_clock_pin,
	input wire logic internal_low_power_osc,
	// Requests and events
	output logic irq_rtc,
	output logic irq_pit,
	output logic evt_wrap,
	output logic evt_compare,
	output logic [7:0] evt_pit
);
	import rtc_pkg::*;

	// Pin synchronisers; stage one feeds only stage two.
	logic [2:0] s1_q, s2_q, s3_q;
	logic [4:0] div_q, div_d;
	logic [2:0] rise;
	always_comb begin
		rise = s2_q & ~s3_q;
		div_d = rise[2] ? div_q + 5'h01 : div_q;
	end
	always_ff @(posedge clk) begin
		s1_q <= {internal_low_power_osc, ext_clock_pin, crystal_input_pin};
		s2_q <= s1_q;
		// The edge detector follows the pins through reset, so release never shows a false edge.
		s3_q <= s2_q;
		div_q <= rst ? 5'h00 : div_d;
	end

	// Register and timebase state.
	rtc_ctrl_t ctrl_q, ctrl_d, ctrl_act_q, ctrl_act_d;
	rtc_pitctrl_t pitc_q, pitc_d, pitc_act_q, pitc_act_d;
	rtc_correction_value_register_t correction_value_register_q, correction_value_register_d;
	rtc_clock_source_select_t clock_source_select_q, clock_source_select_d;
	logic [1:0] inten_q, inten_d, flags_q, flags_d, fset, fclr;
	logic [15:0] cnt_q, cnt_d, cnt_wr_q, cnt_wr_d;
	logic [15:0] per_q, per_d, per_act_q, per_act_d;
	logic [15:0] cmp_q, cmp_d, cmp_act_q, cmp_act_d;
	logic [4:0] busy_q, busy_d;
	logic pi_en_q, pi_en_d, pit_flag_q, pit_flag_d;
	logic [14:0] presc_q, presc_d;
	logic [19:0] acc_q, acc_d, win_q, win_d, acc_sum;
	logic corr_run_q, corr_run_d, pit_prev_q, pit_prev_d, pit_lvl;
	logic [15:0] rdata_q, rdata_d, sum;
	logic irq_rtc_q, irq_rtc_d, irq_pit_q, irq_pit_d;
	logic evt_wrap_q, evt_cmp_q;
	logic [7:0] evt_pit_q, evt_pit_d;
	logic tick, run, fire, rtc_tick, cnt_load, wr_ctrl;
	logic [1:0] step;

	always_comb begin
		// Timebase tick from the selected source.
		case (clock_source_select_q)
			rtc_src_xtal: tick = rise[0];
			rtc_src_ext: tick = rise[1];
			rtc_src_ulp: tick = rise[2];
			rtc_src_ulp32: tick = rise[2] && div_q == `RTC_ULP32_LAST;
			default: tick = 1'b0;
		endcase
		run = ctrl_act_q.en | pitc_act_q.en;
		// Spread err corrections evenly over each correction window.
		acc_sum = acc_q + {13'h0000, correction_value_register_q.err};
		fire = corr_run_q && acc_sum >= CORR_WINDOW;
		step = fire ? (correction_value_register_q.neg ? 2'h2 : 2'h0) : 2'h1;
		sum = {1'b0, presc_q} + {14'h0000, step};
		// The counter ticks when prescaler bit presc changes.
		rtc_tick = tick && run && ((sum >> ctrl_act_q.presc) != ({1'b0, presc_q} >> ctrl_act_q.presc));
		cnt_load = tick && busy_q[`RTC_B_CNT];
		wr_ctrl = bus.wr && bus.addr == `RTC_A_CTRL;
		// Settings cross into the timebase on its next tick.
		ctrl_act_d = tick ? ctrl_q : ctrl_act_q;
		pitc_act_d = tick ? pitc_q : pitc_act_q;
		per_act_d = tick ? per_q : per_act_q;
		cmp_act_d = tick ? cmp_q : cmp_act_q;
		busy_d = tick ? 5'h00 : busy_q;
		ctrl_d = ctrl_q;
		pitc_d = pitc_q;
		correction_value_register_d = correction_value_register_q;
		clock_source_select_d = clock_source_select_q;
		inten_d = inten_q;
		pi_en_d = pi_en_q;
		per_d = per_q;
		cmp_d = cmp_q;
		cnt_wr_d = cnt_wr_q;
		fclr = 2'h0;
		pit_flag_d = pit_flag_q;
		if (bus.wr) begin
			case (bus.addr)
				`RTC_A_CTRL: begin
					ctrl_d = rtc_ctrl_t'(bus.wdata[5:0]);
					busy_d[`RTC_B_CTRL] = 1'b1;
				end
				`RTC_A_INTCTRL: inten_d = bus.wdata[1:0];
				`RTC_A_INTFLAGS: fclr = bus.wdata[1:0];
				`RTC_A_CNT: begin
					cnt_wr_d = bus.wdata;
					busy_d[`RTC_B_CNT] = 1'b1;
				end
				`RTC_A_PER: begin
					per_d = bus.wdata;
					busy_d[`RTC_B_PER] = 1'b1;
				end
				`RTC_A_CMP: begin
					cmp_d = bus.wdata;
					busy_d[`RTC_B_CMP] = 1'b1;
				end
				`RTC_A_CLOCK_SOURCE_SELECT: clock_source_select_d = rtc_clock_source_select_t'(bus.wdata[1:0]);
				`RTC_A_CORRECTION_VALUE_REGISTER: correction_value_register_d = rtc_correction_value_register_t'(bus.wdata[7:0]);
				`RTC_A_PITCTRL: begin
					pitc_d = rtc_pitctrl_t'(bus.wdata[4:0]);
					busy_d[`RTC_B_PIT] = 1'b1;
				end
				`RTC_A_PITINTCTRL: pi_en_d = bus.wdata[0];
				`RTC_A_PITFLAGS: pit_flag_d = pit_flag_q & ~bus.wdata[0];
				default: ;
			endcase
		end
		// Correction window; a window in progress finishes before correction stops.
		acc_d = acc_q;
		win_d = win_q;
		corr_run_d = corr_run_q;
		if (!corr_run_q) begin
			corr_run_d = ctrl_act_q.corr;
			acc_d = 20'h0_0000;
			win_d = 20'h0_0000;
		end else if (tick && run) begin
			acc_d = fire ? acc_sum - CORR_WINDOW : acc_sum;
			win_d = win_q + 20'h0_0001;
			if (win_q == CORR_WINDOW - 20'h0_0001) begin
				win_d = 20'h0_0000;
				acc_d = 20'h0_0000;
				corr_run_d = ctrl_act_q.corr;
			end
		end
		// One shared prescaler; its phase at enable sets the first tick.
		if (!run) presc_d = 15'h0000;
		else if (tick) presc_d = sum[14:0];
		else presc_d = presc_q;
		// Counter with wrap and compare.
		fset = 2'h0;
		cnt_d = cnt_q;
		if (cnt_load) cnt_d = cnt_wr_q;
		else if (rtc_tick && ctrl_act_q.en) begin
			cnt_d = cnt_q + 16'h0001;
			if (cnt_q == per_act_q) begin
				cnt_d = `RTC_ZERO16;
				fset[`RTC_F_OVF] = 1'b1;
			end
			if (cnt_q == cmp_act_q) fset[`RTC_F_CMP] = 1'b1;
		end
		flags_d = (flags_q & ~fclr) | fset;
		// Periodic output follows prescaler bit period, toggling each half period.
		pit_lvl = pitc_act_q.en && pitc_act_q.period >= `RTC_PIT_MIN && pitc_act_q.period <= `RTC_PIT_MAX
			&& presc_q[pitc_act_q.period];
		pit_prev_d = pit_lvl;
		if (pit_lvl && !pit_prev_q) pit_flag_d = 1'b1;
		evt_pit_d = pitc_act_q.en ? presc_q[`RTC_EVT_MSB:`RTC_EVT_LSB] : 8'h00;
		irq_rtc_d = |(flags_q & inten_q);
		irq_pit_d = pit_flag_q & pi_en_q;
		// Read data stand in the cycle after the strobe.
		rdata_d = `RTC_ZERO16;
		if (bus.rd) begin
			case (bus.addr)
				`RTC_A_CTRL: rdata_d = {10'h000, ctrl_q};
				`RTC_A_STATUS: rdata_d = {12'h000, busy_q[3:0]};
				`RTC_A_INTCTRL: rdata_d = {14'h0000, inten_q};
				`RTC_A_INTFLAGS: rdata_d = {14'h0000, flags_q};
				`RTC_A_CNT: rdata_d = cnt_q;
				`RTC_A_PER: rdata_d = per_q;
				`RTC_A_CMP: rdata_d = cmp_q;
				`RTC_A_CLOCK_SOURCE_SELECT: rdata_d = {14'h0000, clock_source_select_q};
				`RTC_A_CORRECTION_VALUE_REGISTER: rdata_d = {8'h00, correction_value_register_q};
				`RTC_A_PITCTRL: rdata_d = {11'h000, pitc_q};
				`RTC_A_PITINTCTRL: rdata_d = {15'h0000, pi_en_q};
				`RTC_A_PITFLAGS: rdata_d = {15'h0000, pit_flag_q};
				`RTC_A_PITSTATUS: rdata_d = {15'h0000, busy_q[`RTC_B_PIT]};
				default: rdata_d = `RTC_ZERO16;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= rtc_ctrl_t'(6'h00);
			ctrl_act_q <= rtc_ctrl_t'(6'h00);
			pitc_q <= rtc_pitctrl_t'(5'h00);
			pitc_act_q <= rtc_pitctrl_t'(5'h00);
			correction_value_register_q <= rtc_correction_value_register_t'(8'h00);
			clock_source_select_q <= rtc_src_xtal;
			inten_q <= 2'h0;
			flags_q <= 2'h0;
			cnt_q <= `RTC_ZERO16;
			cnt_wr_q <= `RTC_ZERO16;
			per_q <= `RTC_PER_RST;
			per_act_q <= `RTC_PER_RST;
			cmp_q <= `RTC_ZERO16;
			cmp_act_q <= `RTC_ZERO16;
			busy_q <= 5'h00;
			pi_en_q <= 1'b0;
			pit_flag_q <= 1'b0;
			presc_q <= 15'h0000;
			acc_q <= 20'h0_0000;
			win_q <= 20'h0_0000;
			corr_run_q <= 1'b0;
			pit_prev_q <= 1'b0;
			rdata_q <= `RTC_ZERO16;
			irq_rtc_q <= 1'b0;
			irq_pit_q <= 1'b0;
			evt_wrap_q <= 1'b0;
			evt_cmp_q <= 1'b0;
			evt_pit_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			ctrl_act_q <= ctrl_act_d;
			pitc_q <= pitc_d;
			pitc_act_q <= pitc_act_d;
			correction_value_register_q <= correction_value_register_d;
			clock_source_select_q <= clock_source_select_d;
			inten_q <= inten_d;
			flags_q <= flags_d;
			cnt_q <= cnt_d;
			cnt_wr_q <= cnt_wr_d;
			per_q <= per_d;
			per_act_q <= per_act_d;
			cmp_q <= cmp_d;
			cmp_act_q <= cmp_act_d;
			busy_q <= busy_d;
			pi_en_q <= pi_en_d;
			pit_flag_q <= pit_flag_d;
			presc_q <= presc_d;
			acc_q <= acc_d;
			win_q <= win_d;
			corr_run_q <= corr_run_d;
			pit_prev_q <= pit_prev_d;
			rdata_q <= rdata_d;
			irq_rtc_q <= irq_rtc_d;
			irq_pit_q <= irq_pit_d;
			evt_wrap_q <= fset[`RTC_F_OVF];
			evt_cmp_q <= fset[`RTC_F_CMP];
			evt_pit_q <= evt_pit_d;
		end
	end

	assign rdata = rdata_q;
	assign irq_rtc = irq_rtc_q;
	assign irq_pit = irq_pit_q;
	assign evt_wrap = evt_wrap_q;
	assign evt_compare = evt_cmp_q;
	assign evt_pit = evt_pit_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	count_step_a: assert property (rtc_tick && ctrl_act_q.en && !cnt_load && cnt_q != per_act_q |=> cnt_q == $past(cnt_q) + 16'h0001) else $error("counter did not step");
	compare_event_a: assert property (rtc_tick && ctrl_act_q.en && !cnt_load && cnt_q == cmp_act_q |=> evt_cmp_q && flags_q[`RTC_F_CMP]) else $error("compare event missing");
	wrap_zero_a: assert property (rtc_tick && ctrl_act_q.en && !cnt_load && cnt_q == per_act_q |=> cnt_q == `RTC_ZERO16 && evt_wrap_q) else $error("wrap failed");
	counter_hold_a: assert property (!ctrl_act_q.en && !cnt_load |=> $stable(cnt_q)) else $error("disabled counter moved");
	presc_stop_a: assert property (!run |=> presc_q == 15'h0000) else $error("prescaler runs while off");
	pit_div16_a: assert property (pitc_act_q.en && pitc_act_q.period == `RTC_PIT_DIV16 |=> pit_prev_q == $past(presc_q[3])) else $error("divide by sixteen not on bit 3");
	skip_count_a: assert property (tick && run && fire && correction_value_register_q.neg |=> presc_q == $past(presc_q) + 15'h0002) else $error("skip correction missing");
	irq_hold_a: assert property ((pit_flag_q && pi_en_q) [*2] |-> irq_pit_q) else $error("periodic request dropped");
	busy_set_a: assert property (wr_ctrl |=> busy_q[`RTC_B_CTRL]) else $error("busy not set");
	busy_hold_a: assert property (busy_q[`RTC_B_CTRL] && !tick |=> busy_q[`RTC_B_CTRL])
		else $error("busy dropped before tick");
	wrap_c: cover property (evt_wrap_q);
	compare_c: cover property (evt_cmp_q);
	pit_flag_c: cover property (!pit_flag_q ##1 pit_flag_q);
	correction_c: cover property (tick && fire);
endmodule : rtc_top

// ===== rtc_src_model.sv
// Timebase source model: a square wave on one timebase pin.
`timescale 1ns/100ps
module rtc_src_model #(
	parameter int HALF = 3
) (
	// Reference clock and control
	input wire logic clk,
	input wire logic run,
	// Generated timebase
	output logic pin
);
	int cnt_q;
	// Each level lasts HALF fast clocks, and at least two are needed so the synchroniser sees every level.
	initial begin
		pin = 1'b0;
		cnt_q = 0;
	end
	always @(posedge clk) begin
		if (run) begin
			if (cnt_q == HALF - 1) begin
				cnt_q <= 0;
				pin <= ~pin;
			end else begin
				cnt_q <= cnt_q + 1;
			end
		end
	end
endmodule : rtc_src_model

// ===== rtc_counter_and_periodic_timer_test.sv
// Self-checking testbench of the real-time counter and periodic timer.
`timescale 1ns/100ps
`include "rtc_defs.svh"
module rtc_counter_and_periodic_timer_test;
	import rtc_pkg::*;
	localparam int XH = 3;
	localparam int EH = 4;
	localparam int OH = 2;
	logic clk, rst, xtal, extc, osc, irq_rtc, irq_pit, evt_wrap, evt_compare;
	rtc_bus_t bus;
	logic [15:0] rdata, v, w;
	logic [7:0] evt_pit;
	int mismatches, checked, cyc, seed, t0, t1, p, c, d;
	rtc_top #(.CORR_WINDOW(20'h0_0040)) i_dut(.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.crystal_input_pin(xtal), .ext_clock_pin(extc), .internal_low_power_osc(osc), .irq_rtc(irq_rtc),
		.irq_pit(irq_pit), .evt_wrap(evt_wrap), .evt_compare(evt_compare), .evt_pit(evt_pit));
	rtc_src_model #(.HALF(XH)) i_xtal(.clk(clk), .run(1'b1), .pin(xtal));
	rtc_src_model #(.HALF(EH)) i_ext(.clk(clk), .run(1'b1), .pin(extc));
	rtc_src_model #(.HALF(OH)) i_osc(.clk(clk), .run(1'b1), .pin(osc));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// Clock cycles taken by a number of timebase ticks.
	function automatic int gap(input int ticks, input int half);
		return ticks * 2 * half;
	endfunction : gap
	task automatic stop_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check_val(input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : check_val
	task automatic check_gap(input int exp, input int got);
		checked++;
		if (got != exp) begin
			mismatches++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : check_gap
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	// Polls both busy registers so configuration is never written over a pending update.
	task automatic wait_idle();
		logic [15:0] s, q;
		for (int i = 0; i < 100; i++) begin
			rd(`RTC_A_STATUS, s);
			rd(`RTC_A_PITSTATUS, q);
			if ((s | q) === 16'h0000) return;
		end
		mismatches++;
		stop_test();
	endtask : wait_idle
	task automatic wait_sig(input int which, output int t);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			if ((which == 0 && evt_wrap === 1'b1) || (which == 1 && evt_compare === 1'b1) ||
				(which == 2 && irq_pit === 1'b1) || (which == 3 && evt_pit[0] === 1'b1) ||
				(which == 4 && evt_pit[0] === 1'b0)) begin
				t = cyc;
				return;
			end
		end
		mismatches++;
		stop_test();
	endtask : wait_sig
	// One wrap is skipped so the measured interval lies wholly under the new setting.
	task automatic wrap_gap(output int g);
		int a, b;
		wait_sig(0, a);
		wait_sig(0, a);
		wait_sig(0, b);
		g = b - a;
	endtask : wrap_gap
	initial begin
		seed = 32'h7262;
		rst = 1'b1;
		bus = '0;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(`RTC_A_PER, v);
		check_val(16'hFFFF, v);
		rd(`RTC_A_CNT, v);
		check_val(16'h0000, v);
		rd(4'hD, v);
		check_val(16'h0000, v);
		wr(`RTC_A_CLOCK_SOURCE_SELECT, 16'h0000);
		wait_idle();
		wr(`RTC_A_PER, 16'h0002);
		wr(`RTC_A_CMP, 16'h0001);
		wr(`RTC_A_INTCTRL, 16'h0003);
		wr(`RTC_A_CTRL, 16'h0001);
		wait_idle();
		wait_sig(0, t0);
		wait_sig(0, t1);
		check_gap(gap(3, XH), t1 - t0);
		wait_sig(1, t0);
		wait_sig(0, t1);
		check_gap(gap(1, XH), t1 - t0);
		rd(`RTC_A_INTFLAGS, v);
		check_val(16'h0003, v);
		check_val(16'h0001, {15'h0000, irq_rtc});
		wr(`RTC_A_INTCTRL, 16'h0000);
		@(posedge clk);
		#1 check_val(16'h0000, {15'h0000, irq_rtc});
		// Count is cleared first so a shorter period can never leave it above the new wrap value.
		for (int k = 0; k < 4; k++) begin
			p = 2 + ($random(seed) & 7);
			c = ($random(seed) & 32'h7FFF_FFFF) % p;
			wr(`RTC_A_CNT, 16'h0000);
			wr(`RTC_A_PER, 16'(p));
			wr(`RTC_A_CMP, 16'(c));
			wait_idle();
			wait_sig(0, t0);
			wait_sig(0, t1);
			check_gap(gap(p + 1, XH), t1 - t0);
			wait_sig(1, t0);
			wait_sig(0, t1);
			check_gap(gap(p - c, XH), t1 - t0);
			repeat ($random(seed) & 15) @(posedge clk);
			rd(`RTC_A_CNT, v);
			check_val(16'h0001, {15'h0000, v <= 16'(p)});
		end
		wr(`RTC_A_CLOCK_SOURCE_SELECT, 16'h0001);
		wait_sig(0, t0);
		wait_sig(0, t0);
		wait_sig(0, t1);
		check_gap(gap(p + 1, EH), t1 - t0);
		wr(`RTC_A_CLOCK_SOURCE_SELECT, 16'h0002);
		wrap_gap(d);
		check_gap(gap(p + 1, OH), d);
		wr(`RTC_A_CLOCK_SOURCE_SELECT, 16'h0003);
		wrap_gap(d);
		check_gap(gap((p + 1) * 32, OH), d);
		wr(`RTC_A_CLOCK_SOURCE_SELECT, 16'h0000);
		wr(`RTC_A_CTRL, 16'h0009);
		wait_idle();
		wrap_gap(d);
		check_gap(gap(4 * (p + 1), XH), d);
		// Half the window as error makes every second tick an inserted one.
		wr(`RTC_A_CORRECTION_VALUE_REGISTER, 16'h0020);
		wr(`RTC_A_CTRL, 16'h0003);
		wait_idle();
		wrap_gap(d);
		check_gap(gap(2 * (p + 1), XH), d);
		// Skipping needs at least divide by two, so the prescaler is set before the sign.
		wr(`RTC_A_CTRL, 16'h0007);
		wait_idle();
		wr(`RTC_A_CORRECTION_VALUE_REGISTER, 16'h00C0);
		wrap_gap(d);
		check_gap(gap(p + 1, XH), d);
		wr(`RTC_A_CORRECTION_VALUE_REGISTER, 16'h0000);
		wr(`RTC_A_CTRL, 16'h0000);
		wait_idle();
		rd(`RTC_A_CNT, v);
		repeat (60) @(posedge clk);
		rd(`RTC_A_CNT, w);
		check_val(v, w);
		check_val(16'h0000, {8'h00, evt_pit});
		wr(`RTC_A_PITINTCTRL, 16'h0001);
		wr(`RTC_A_PITCTRL, 16'h0007);
		wait_idle();
		wait_sig(2, t0);
		wr(`RTC_A_PITFLAGS, 16'h0001);
		repeat (2) @(posedge clk);
		wait_sig(2, t1);
		check_gap(gap(16, XH), t1 - t0);
		wait_sig(4, t0);
		wait_sig(3, t0);
		wait_sig(4, t1);
		wait_sig(3, t1);
		check_gap(gap(64, XH), t1 - t0);
		wr(`RTC_A_PITCTRL, 16'h0000);
		wait_idle();
		wr(`RTC_A_PITFLAGS, 16'h0001);
		repeat (200) @(posedge clk);
		#1 check_val(16'h0000, {15'h0000, irq_pit});
		check_val(16'h0000, {8'h00, evt_pit});
		stop_test();
	end
endmodule : rtc_counter_and_periodic_timer_test
